// ---- logic/lsiu_core.sv ----
// sequence and bit-control instruction unit behind an ahb-lite slave
// assumes one bus master, single word transfers, software drives the scan
//
// Operation
// R1 - step advance ends step, starts next
// R2 - bit shift register across word range
// R3 - program keeps first word <= last
// R4 - latch bit set and reset inputs
// R5 - counter counts on input off-to-on edges
// R6 - counter set value 0-9999, reset input
// R7 - rising pulse bit on one scan
// R8 - falling pulse bit on one scan
// R9 - fast timer decrementing on-delay, 0.01 s
// R10 - program uses each timer number once
// R11 - word shift left, zeros into first
// R12 - compare sets above, same, below flags
// R13 - bit address: word = number / 100
// R14 - latch reset wins over set
// R15 - shift on pulse edge, data into bit0
`timescale 1ns/1ps
module lsiu_core
    import lsiu_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TIMER_TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);
    import lsiu_pkg::*;

    // ********************************************************
    // ahb-lite slave
    // ********************************************************
    logic        wr_q;
    logic [7:0]  waddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata;
    wire         accept = hsel && htrans[1] && hready;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q     <= 1'b0;
            waddr_q  <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_q     <= accept && hwrite;
            waddr_q  <= haddr[7:0];
            hrdata_q <= (accept && !hwrite) ? rdata : hrdata_q;
        end
    end

    wire wr_inputs = wr_q && (waddr_q == OFS_INPUTS);
    wire scan      = wr_q && (waddr_q == OFS_SCAN);
    wire wr_range  = wr_q && (waddr_q == OFS_RANGE);
    wire wr_cnt_sv = wr_q && (waddr_q == OFS_CNT_SV);
    wire wr_tmr_sv = wr_q && (waddr_q == OFS_TMR_SV);
    wire wr_cmp_a  = wr_q && (waddr_q == OFS_CMP_A);
    wire wr_cmp_b  = wr_q && (waddr_q == OFS_CMP_B);
    wire wr_bitadr = wr_q && (waddr_q == OFS_BIT_ADR);

    // ********************************************************
    // software registers
    // ********************************************************
    logic [IN_W-1:0]    inputs_q;
    logic [IDX_W-1:0]   first_q;
    logic [IDX_W-1:0]   last_q;
    logic [15:0]        cnt_sv_q;
    logic [15:0]        tmr_sv_q;
    logic [15:0]        cmp_a_q;
    logic [15:0]        cmp_b_q;
    logic [14:0]        bit_adr_q;
    logic [15:0]        scan_count_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inputs_q     <= '0;
            first_q      <= RANGE_RST[RANGE_FIRST_LSB +: IDX_W];
            last_q       <= RANGE_RST[RANGE_LAST_LSB +: IDX_W];
            cnt_sv_q     <= CNT_SV_RST;
            tmr_sv_q     <= TMR_SV_RST;
            cmp_a_q      <= 16'h0000;
            cmp_b_q      <= 16'h0000;
            bit_adr_q    <= 15'h0000;
            scan_count_q <= 16'h0000;
        end else begin
            if (wr_inputs) inputs_q  <= hwdata[IN_W-1:0];
            if (wr_range) begin
                first_q <= hwdata[RANGE_FIRST_LSB +: IDX_W];
                last_q  <= hwdata[RANGE_LAST_LSB +: IDX_W];
            end
            if (wr_cnt_sv) cnt_sv_q  <= hwdata[15:0];   // see R6
            if (wr_tmr_sv) tmr_sv_q  <= hwdata[15:0];   // see R9
            if (wr_cmp_a)  cmp_a_q   <= hwdata[15:0];
            if (wr_cmp_b)  cmp_b_q   <= hwdata[15:0];
            if (wr_bitadr) bit_adr_q <= hwdata[14:0];
            if (scan)      scan_count_q <= scan_count_q + 16'h0001;
        end
    end

    // ********************************************************
    // per-scan edges of pulse-type inputs
    // ********************************************************
    logic [3:0] edge_rise;
    logic [3:0] edge_fall;

    lsiu_edge #(.W(4)) u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sample  (scan),
        .din     ({inputs_q[IN_PULSE], inputs_q[IN_DECREMENT],
                   inputs_q[IN_INCREMENT], inputs_q[IN_SHIFT_PULS]}),
        .rise    (edge_rise),
        .fall    (edge_fall)
    );

    wire shift_edge = edge_rise[0];   // see R15
    wire inc_edge   = edge_rise[1];   // see R5
    wire dec_edge   = edge_rise[2];   // see R5
    wire pulse_rise = edge_rise[3];   // see R7
    wire pulse_fall = edge_fall[3];   // see R8

    // ********************************************************
    // scan-evaluated bits: latch, pulses, step, compare
    // ********************************************************
    logic       latch_q;
    logic       rise_q;
    logic       fall_q;
    logic [7:0] step_q;
    logic       above_q;
    logic       same_q;
    logic       below_q;
    logic       pulse_seen_q;

    wire latch_set = inputs_q[IN_LATCH_SET];
    wire latch_rst = inputs_q[IN_LATCH_RST];
    wire step_adv  = inputs_q[IN_STEP_ADV];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
            step_q  <= 8'h00;
            above_q <= 1'b0;
            same_q  <= 1'b0;
            below_q <= 1'b0;
            pulse_seen_q <= 1'b0;
        end else if (scan) begin
            // reset is tested first so a same-scan set cannot turn the bit on
            if (latch_rst) latch_q <= 1'b0;        // see R14
            else if (latch_set) latch_q <= 1'b1;   // see R4
            rise_q  <= pulse_rise;                 // see R7
            fall_q  <= pulse_fall;                 // see R8
            if (step_adv) step_q <= step_q + 8'h01;   // see R1
            above_q <= cmp_a_q > cmp_b_q;          // see R12
            same_q  <= cmp_a_q == cmp_b_q;
            below_q <= cmp_a_q < cmp_b_q;
            pulse_seen_q <= inputs_q[IN_PULSE];   // kept apart from the edge detector
        end
    end

    chk_latch_rst_wins: assert property (@(posedge hclk) disable iff (!hresetn) // see R14
        scan && latch_rst |=> !latch_q)
        else $error("latch on after reset input");
    chk_latch_set_on: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
        scan && latch_set && !latch_rst |=> latch_q ##1 (latch_q || $past(scan)))
        else $error("latch not set");
    chk_rise_one_scan: assert property (@(posedge hclk) disable iff (!hresetn) // see R7
        rise_q && scan && !pulse_rise |=> !rise_q)
        else $error("rising pulse longer than one scan");
    chk_fall_on_edge: assert property (@(posedge hclk) disable iff (!hresetn) // see R8
        scan && pulse_seen_q && !inputs_q[IN_PULSE] |=> fall_q)
        else $error("falling pulse missing");
    chk_step_next: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
        scan && step_adv |=> step_q == $past(step_q) + 8'h01)
        else $error("step did not advance");
    chk_compare_flags: assert property (@(posedge hclk) disable iff (!hresetn) // see R12
        scan |=> (above_q == ($past(cmp_a_q) > $past(cmp_b_q)))
                 && (above_q + same_q + below_q == 2'd1))
        else $error("compare flags wrong");

    // ********************************************************
    // updown counter
    // ********************************************************
    logic [15:0] cnt_pv;
    wire         cnt_rst = inputs_q[IN_CNT_RST];

    lsiu_bcd_cnt u_counter (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .load       (scan && cnt_rst),                // see R6
        .load_value (CNT_PV_RST),
        .up         (scan && !cnt_rst && inc_edge),   // see R5
        .down       (scan && !cnt_rst && dec_edge),   // see R5
        .count      (cnt_pv)
    );

    wire cnt_done = (cnt_pv == cnt_sv_q);

    chk_cnt_reset: assert property (@(posedge hclk) disable iff (!hresetn) // see R6
        scan && cnt_rst |=> cnt_pv == CNT_PV_RST)
        else $error("counter not cleared by reset input");
    chk_cnt_moves: assert property (@(posedge hclk) disable iff (!hresetn) // see R5
        scan && !cnt_rst && (inc_edge != dec_edge) |=> cnt_pv != $past(cnt_pv))
        else $error("counter ignored an edge");

    // ********************************************************
    // fast delay timer, counts down in 0.01 s ticks
    // ********************************************************
    logic [31:0] tick_cnt_q;
    logic [15:0] tmr_pv;
    wire         tmr_en   = inputs_q[IN_TMR_EN];
    wire         tick     = tmr_en && (tick_cnt_q == TICK_CYCLES - 1);
    wire         tmr_zero = (tmr_pv == 16'h0000);
    wire         tmr_done = tmr_en && tmr_zero;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (!tmr_en || tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    // an idle timer keeps reloading, so a new set value applies at the next start
    lsiu_bcd_cnt u_timer (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .load       (!tmr_en),                        // see R9
        .load_value (tmr_sv_q),
        .up         (1'b0),
        .down       (tmr_en && tick && !tmr_zero),    // see R9
        .count      (tmr_pv)
    );

    chk_timer_reload: assert property (@(posedge hclk) disable iff (!hresetn) // see R9
        !tmr_en |=> tmr_pv == $past(tmr_sv_q))
        else $error("idle timer not at set value");

    // ********************************************************
    // data words: bit shift and word shift over first..last
    // ********************************************************
    logic [WORD_W-1:0] data_q [NUM_WORDS];
    logic [WORD_W-1:0] data_d [NUM_WORDS];
    wire range_ok   = (first_q <= last_q);   // see R3
    wire shift_rst  = scan && inputs_q[IN_SHIFT_RST];
    wire bit_shift  = scan && !inputs_q[IN_SHIFT_RST] && shift_edge;
    wire word_shift = scan && inputs_q[IN_WORD_SHIFT];
    wire wr_data    = wr_q && (waddr_q[7:5] == OFS_DATA0[7:5]);

    genvar i;
    generate
        for (i = 0; i < NUM_WORDS; i++) begin : g_word
            wire               in_range = range_ok && (i >= first_q) && (i <= last_q);
            wire               is_first = (i == first_q);
            wire               carry_in;
            wire [WORD_W-1:0]  prev_word;
            if (i == 0) begin : g_lo
                assign carry_in  = 1'b0;
                assign prev_word = '0;
            end else begin : g_up
                assign carry_in  = data_q[i-1][WORD_W-1];
                assign prev_word = data_q[i-1];
            end
            wire [WORD_W-1:0] bit_next =
                {data_q[i][WORD_W-2:0], is_first ? inputs_q[IN_SHIFT_DATA] : carry_in};
            wire [WORD_W-1:0] word_next = is_first ? '0 : prev_word;
            assign data_d[i] =
                (wr_data && waddr_q[4:2] == i) ? hwdata[WORD_W-1:0] :
                (shift_rst && in_range)        ? '0 :          // see R2
                (bit_shift && in_range)        ? bit_next :    // see R2 see R15
                (word_shift && in_range)       ? word_next :   // see R11
                data_q[i];
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < NUM_WORDS; k++) data_q[k] <= '0;
        end else begin
            for (int k = 0; k < NUM_WORDS; k++) data_q[k] <= data_d[k];
        end
    end

    chk_word_shift_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see R11
        word_shift && !bit_shift && !shift_rst && range_ok |=> data_q[$past(first_q)] == '0)
        else $error("first word not zeroed by word shift");
    chk_bit_shift_in: assert property (@(posedge hclk) disable iff (!hresetn) // see R15
        bit_shift && range_ok |=> data_q[$past(first_q)][0] == $past(inputs_q[IN_SHIFT_DATA]))
        else $error("shift data not taken into bit 0");

    // ********************************************************
    // decimal bit address probe
    // ********************************************************
    wire [14:0] probe_word = bit_adr_q / BITS_PER_WORD_NUM;   // see R13
    wire [14:0] probe_bit  = bit_adr_q % BITS_PER_WORD_NUM;   // see R13
    wire        probe_io   = (bit_adr_q <= IO_LAST_BIT);
    wire        probe_spec = (bit_adr_q >= SPECIAL_FIRST_BIT) &&
                             (bit_adr_q <= SPECIAL_LAST_BIT);
    wire        probe_ok   = (probe_bit < 15'd16);
    wire        probe_val  = probe_ok && (probe_word < 15'(NUM_WORDS)) &&
                             data_q[probe_word[IDX_W-1:0]][probe_bit[3:0]];

    // ********************************************************
    // read mux
    // ********************************************************
    wire [15:0] status = {step_q, below_q, same_q, above_q, cnt_done, tmr_done,
                          fall_q, rise_q, latch_q};
    wire [7:0]  raddr  = haddr[7:0];

    assign rdata =
        (raddr == OFS_INPUTS)          ? {20'h00000, inputs_q} :
        (raddr == OFS_SCAN)            ? {16'h0000, scan_count_q} :
        (raddr == OFS_RANGE)           ? {24'h000000, 1'b0, last_q, 1'b0, first_q} :
        (raddr == OFS_CNT_SV)          ? {16'h0000, cnt_sv_q} :
        (raddr == OFS_TMR_SV)          ? {16'h0000, tmr_sv_q} :
        (raddr == OFS_CMP_A)           ? {16'h0000, cmp_a_q} :
        (raddr == OFS_CMP_B)           ? {16'h0000, cmp_b_q} :
        (raddr == OFS_STATUS)          ? {16'h0000, status} :
        (raddr == OFS_CNT_PV)          ? {16'h0000, cnt_pv} :
        (raddr == OFS_TMR_PV)          ? {16'h0000, tmr_pv} :
        (raddr == OFS_BIT_ADR)         ? {12'h000, probe_val, probe_ok, probe_spec,
                                          probe_io, 1'b0, bit_adr_q} :
        (raddr[7:5] == OFS_DATA0[7:5]) ? {16'h0000, data_q[raddr[4:2]]} :
        32'h0000_0000;
endmodule

// ---- logic/lsiu_pkg.sv ----
// constants shared by the sequence instruction unit and its helpers
// assumes a 100 MHz hclk and byte-addressed AHB-Lite register access at word-aligned offsets
package lsiu_pkg;

    // ********************************************************
    // clock and time base
    // ********************************************************
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned TIMER_UNIT_NS     = 10_000_000;   // timer counts in 0.01 s
    localparam int unsigned TIMER_TICK_CYCLES = TIMER_UNIT_NS / CLK_PERIOD_NS;

    // ********************************************************
    // data words
    // ********************************************************
    localparam int unsigned NUM_WORDS = 8;
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned IDX_W     = 3;

    // ********************************************************
    // register byte offsets
    // ********************************************************
    localparam logic [7:0] OFS_INPUTS  = 8'h00;
    localparam logic [7:0] OFS_SCAN    = 8'h04;
    localparam logic [7:0] OFS_RANGE   = 8'h08;
    localparam logic [7:0] OFS_CNT_SV  = 8'h0c;
    localparam logic [7:0] OFS_TMR_SV  = 8'h10;
    localparam logic [7:0] OFS_CMP_A   = 8'h14;
    localparam logic [7:0] OFS_CMP_B   = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_CNT_PV  = 8'h20;
    localparam logic [7:0] OFS_TMR_PV  = 8'h24;
    localparam logic [7:0] OFS_BIT_ADR = 8'h28;
    localparam logic [7:0] OFS_DATA0   = 8'h40;

    // ********************************************************
    // input register fields
    // ********************************************************
    localparam int unsigned IN_LATCH_SET  = 0;
    localparam int unsigned IN_LATCH_RST  = 1;
    localparam int unsigned IN_SHIFT_DATA = 2;
    localparam int unsigned IN_SHIFT_PULS = 3;
    localparam int unsigned IN_SHIFT_RST  = 4;
    localparam int unsigned IN_INCREMENT  = 5;
    localparam int unsigned IN_DECREMENT  = 6;
    localparam int unsigned IN_CNT_RST    = 7;
    localparam int unsigned IN_PULSE      = 8;
    localparam int unsigned IN_TMR_EN     = 9;
    localparam int unsigned IN_STEP_ADV   = 10;
    localparam int unsigned IN_WORD_SHIFT = 11;
    localparam int unsigned IN_W          = 12;

    // range register fields
    localparam int unsigned RANGE_FIRST_LSB = 0;
    localparam int unsigned RANGE_LAST_LSB  = 4;

    // status register fields
    localparam int unsigned ST_LATCH    = 0;
    localparam int unsigned ST_RISE     = 1;
    localparam int unsigned ST_FALL     = 2;
    localparam int unsigned ST_TMR_DONE = 3;
    localparam int unsigned ST_CNT_DONE = 4;
    localparam int unsigned ST_ABOVE    = 5;
    localparam int unsigned ST_SAME     = 6;
    localparam int unsigned ST_BELOW    = 7;
    localparam int unsigned ST_STEP_LSB = 8;

    // ********************************************************
    // reset values and bcd limits
    // ********************************************************
    localparam logic [15:0] CNT_SV_RST   = 16'h0000;
    localparam logic [15:0] TMR_SV_RST   = 16'h0002;
    localparam logic [15:0] CNT_PV_RST   = 16'h0000;
    localparam logic [7:0]  RANGE_RST    = 8'h00;
    localparam logic [3:0]  BCD_NINE     = 4'h9;

    // ********************************************************
    // bit address numbering
    // ********************************************************
    localparam logic [14:0] BITS_PER_WORD_NUM = 15'd100;
    localparam logic [14:0] IO_LAST_BIT       = 15'd23615;
    localparam logic [14:0] SPECIAL_FIRST_BIT = 15'd23700;
    localparam logic [14:0] SPECIAL_LAST_BIT  = 15'd25515;

endpackage

// ---- logic/lsiu_edge.sv ----
// per-scan edge detector for a group of input bits
// assumes sample is a one-cycle scan strobe
`timescale 1ns/1ps
module lsiu_edge #(
    parameter int unsigned W = 4
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         sample,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] prev_q;

    // edges are judged against the value seen at the previous scan only
    assign rise = {W{sample}} & din & ~prev_q;
    assign fall = {W{sample}} & ~din & prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= '0;
        end else if (sample) begin
            prev_q <= din;
        end
    end
endmodule

// ---- logic/lsiu_bcd_cnt.sv ----
// four-digit bcd up/down counter with load, wrapping 9999 <-> 0000
// assumes up and down are one-cycle strobes; both together hold the count
`timescale 1ns/1ps
module lsiu_bcd_cnt
    import lsiu_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    input  wire logic        up,
    input  wire logic        down,
    output logic      [15:0] count
);
    logic [15:0] count_d;
    logic [4:0]  carry;

    assign carry[0] = up ^ down;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_digit
            logic [3:0] dig;
            logic [3:0] inc;
            logic [3:0] dec;
            assign dig = count[4*g +: 4];
            assign inc = (dig == BCD_NINE) ? 4'h0 : dig + 4'h1;
            assign dec = (dig == 4'h0) ? BCD_NINE : dig - 4'h1;
            assign carry[g+1] = carry[g] & (up ? (dig == BCD_NINE) : (dig == 4'h0));
            assign count_d[4*g +: 4] = !carry[g] ? dig : (up ? inc : dec);
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= CNT_PV_RST;
        end else if (load) begin
            count <= load_value;
        end else begin
            count <= count_d;
        end
    end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the sequence instruction unit, driven over ahb-lite
// assumes one slave whose hreadyout is fed back as hready, timer tick of 4 cycles
`timescale 1ns/1ps
module tb_top;
    import lsiu_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic        rd_dp;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] a;
    logic [15:0] b;
    logic [63:0] exp_q[$];
    int          n_fail;
    int          compares;
    int          cycles;
    int          seed;
    int          i;

    assign hready = hreadyout;

    lsiu_core #(.TICK_CYCLES(4)) u_lsiu_core (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ****************************************************************
    // bus master and result watcher
    // ****************************************************************
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the trailing idle cycle lets a read see state written at the previous edge
    task automatic bus(input logic [7:0] ad, input logic wr, input logic [31:0] d);
        haddr  <= {24'h000000, ad};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel   <= 1'b1;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(ad, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        bus(ad, 1'b0, 32'h00000000);
    endtask

    task automatic scan(input logic [31:0] v);
        wr(OFS_INPUTS, v);
        wr(OFS_SCAN, 32'h00000000);
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [63:0] note);
        compares++;
        if ((got & note[63:32]) !== (note[31:0] & note[63:32])) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, note[31:0]);
        end
    endtask

    task automatic cmp_resp(input logic got);
        compares++;
        if (got !== 1'b0) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, 1'b0);
        end
    endtask

    always @(posedge hclk) begin
        if (rd_dp && hready) begin
            cmp_word(hrdata, exp_q.pop_front());
            cmp_resp(hresp);
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
    end

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        seed = 36448;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        rd_dp = 1'b0;
        cycles = 0;
        n_fail = 0;
        compares = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_TMR_SV, 32'h2, 32'hffffffff);
        rd(8'h30, 32'h0, 32'hffffffff);
        scan(32'h1);
        rd(OFS_STATUS, 32'h1, 32'h1);
        scan(32'h3);
        rd(OFS_STATUS, 32'h0, 32'h1);
        scan(32'h1);
        scan(32'h0);
        rd(OFS_STATUS, 32'h1, 32'h1);
        scan(32'h100);
        rd(OFS_STATUS, 32'h2, 32'h6);
        scan(32'h100);
        rd(OFS_STATUS, 32'h0, 32'h6);
        scan(32'h0);
        rd(OFS_STATUS, 32'h4, 32'h6);
        scan(32'h0);
        rd(OFS_STATUS, 32'h0, 32'h6);
        wr(OFS_CNT_SV, 32'h3);
        for (i = 0; i < 3; i++) begin
            scan(32'h20);
            scan(32'h0);
        end
        rd(OFS_CNT_PV, 32'h3, 32'hffffffff);
        rd(OFS_STATUS, 32'h10, 32'h10);
        scan(32'h80);
        rd(OFS_CNT_PV, 32'h0, 32'hffffffff);
        scan(32'h0);
        scan(32'h40);
        rd(OFS_CNT_PV, 32'h9999, 32'hffffffff);
        scan(32'h0);
        scan(32'h60);
        rd(OFS_CNT_PV, 32'h9999, 32'hffffffff);
        scan(32'h400);
        scan(32'h400);
        rd(OFS_STATUS, 32'h200, 32'hff00);
        for (i = 0; i < 5; i++) begin
            a = 16'($random(seed));
            b = (i == 4) ? a : 16'($random(seed));
            wr(OFS_CMP_A, {16'h0000, a});
            wr(OFS_CMP_B, {16'h0000, b});
            scan(32'h0);
            rd(OFS_STATUS, {24'h0, a < b, a == b, a > b, 5'h00}, 32'he0);
        end
        wr(OFS_RANGE, 32'h21);
        wr(OFS_DATA0 + 8'h04, 32'h8001);
        wr(OFS_DATA0 + 8'h08, 32'h0001);
        scan(32'hc);
        rd(OFS_DATA0 + 8'h04, 32'h3, 32'hffffffff);
        rd(OFS_DATA0 + 8'h08, 32'h3, 32'hffffffff);
        scan(32'hc);
        rd(OFS_DATA0 + 8'h04, 32'h3, 32'hffffffff);
        scan(32'h0);
        scan(32'h18);
        rd(OFS_DATA0 + 8'h04, 32'h0, 32'hffffffff);
        wr(OFS_RANGE, 32'h31);
        for (i = 1; i < 4; i++) begin
            wr(OFS_DATA0 + 8'(4 * i), 32'(16'h1111 * i));
        end
        scan(32'h800);
        for (i = 1; i < 4; i++) begin
            rd(OFS_DATA0 + 8'(4 * i), 32'(16'h1111 * (i - 1)), 32'hffffffff);
        end
        scan(32'h0);
        wr(OFS_BIT_ADR, 32'd200);
        rd(OFS_BIT_ADR, 32'hd00c8, 32'hfffff);
        wr(OFS_BIT_ADR, 32'd23615);
        rd(OFS_BIT_ADR, 32'h55c3f, 32'hfffff);
        wr(OFS_BIT_ADR, 32'd23616);
        rd(OFS_BIT_ADR, 32'h05c40, 32'hfffff);
        wr(OFS_BIT_ADR, 32'd23700);
        rd(OFS_BIT_ADR, 32'h65c94, 32'hfffff);
        wr(OFS_TMR_SV, 32'h5);
        rd(OFS_TMR_PV, 32'h5, 32'hffffffff);
        wr(OFS_INPUTS, 32'h200);
        rd(OFS_STATUS, 32'h0, 32'h8);
        repeat (30) @(posedge hclk);
        rd(OFS_TMR_PV, 32'h0, 32'hffffffff);
        rd(OFS_STATUS, 32'h8, 32'h8);
        print_verdict();
    end
endmodule
